// ==== tcsc_pkg.sv ====
// Constants, types and default tables for the trellis/scrambler symbol coder.
// Assumes one 40 MHz reference clock shared by the whole coder.
package tcsc_pkg;
    localparam longint unsigned CLK_HZ = 64'd40_000_000;
    // Symbol rates in millibaud, as specified
    localparam longint unsigned BAUD_TWO_PAIR_MILLI = 64'd233_600_000;
    localparam longint unsigned BAUD_ONE_PAIR_MILLI = 64'd386_667_000;
    localparam int unsigned PPM_TWO_PAIR = 110;
    localparam int unsigned PPM_ONE_PAIR = 90;
    // 32-bit phase step; rounding error is far below the ppm tolerance
    localparam logic [31:0] NCO_INC_TWO_PAIR =
        32'((BAUD_TWO_PAIR_MILLI * 64'h1_0000_0000) / (CLK_HZ * 64'd1000));
    localparam logic [31:0] NCO_INC_ONE_PAIR =
        32'((BAUD_ONE_PAIR_MILLI * 64'h1_0000_0000) / (CLK_HZ * 64'd1000));
    localparam logic [31:0] NCO_RST = 32'h0;

    localparam logic [2:0] GRP_TWO_PAIR = 3'h5;
    localparam logic [2:0] GRP_ONE_PAIR = 3'h6;
    localparam logic [2:0] GRP_UNCODED = 3'h6;
    localparam int unsigned SCR_LEN = 23;
    localparam int unsigned TAP_CUSTOMER = 18;
    localparam int unsigned TAP_EXCHANGE = 5;
    localparam logic [22:0] SCR_RST = 23'h0;
    localparam logic [2:0] TRELLIS_RST = 3'h0;
    localparam int unsigned MAP_POINTS = 128;
    localparam logic [7:0] Y0_DEFAULT = 8'haa;

    typedef enum logic {
        TCSC_SELF_SYNC = 1'b0,
        TCSC_LOCKED = 1'b1
    } tcsc_scr_mode_t;

    typedef struct packed {
        logic [6:0] mapped;
        logic [6:0] point;
    } tcsc_sym_t;

    // Systematic feedback code: next = {s0, s2^I2, s1^I1}, redundant bit = s0
    function automatic logic [95:0] tcsc_trellis_default();
        logic [95:0] t;
        logic [2:0] s;
        t = '0;
        for (int i = 0; i < 32; i++) begin
            s = 3'(i / 4);
            if (i < 32) begin
                t[(i % 32) * 3 +: 3] = 3'h0;
            end
        end
        for (int i = 0; i < 32; i++) begin
            s = 3'(i / 4);
            if (i < 32) begin
                t[(i % 32) * 3 +: 3] = {s[0], s[2] ^ 1'((i / 2) % 2), s[1] ^ 1'(i % 2)};
            end
        end
        return t;
    endfunction

    function automatic logic [895:0] tcsc_map_default();
        logic [895:0] m;
        m = '0;
        for (int i = 0; i < 128; i++) begin
            m[i * 7 +: 7] = 7'(i);
        end
        return m;
    endfunction
endpackage

// ==== tcsc_coder.sv ====
// Transmit and receive bit-level coder: scramblers, symbol grouping, trellis, mapping.
// Assumes configuration inputs and the receive decision path share ref_clk.
//
// Operation
// - One-pair mode carries the whole payload at 2320 kbit/s.
// - Two-pair mode runs each transceiver at 1168 kbit/s.
// - Two-pair uses coded 64 points, one-pair coded 128 points.
// - Output is trellis-coded CAP symbols; precoding sits downstream.
// - Start-up sends uncoded 64 points, first bit is the lsb.
// - Trellis code is 2D, eight states, no differential feature.
// - Every coded symbol carries exactly one redundant bit.
// - Two-pair groups are five scrambled bits, earliest bit lsb.
// - One-pair groups are six scrambled bits, earliest bit lsb.
// - First two group bits drive systematic encoder giving redundant bit.
// - 64-point: redundant bit plus five bits form mapped bits 0-5.
// - 128-point: redundant bit plus six bits form mapped bits 0-6.
// - Scrambler and descrambler use different polynomials per direction.
// - Customer side transmits with taps 18 and 23.
// - Exchange side transmits with taps 5 and 23.
// - Self-sync scrambler divides by polynomial, output fed back.
// - Self-sync descrambler multiplies by polynomial, fed from received bits.
// - Locked mode XORs a free-running generator on and off.
// - Switch to locked only while transmit data is one, uncoordinated.
// - Every frame bit passes the scrambler.
// - Two-pair symbol rate 233.60 kbaud within 110 ppm.
// - One-pair symbol rate 386.667 kbaud within 90 ppm.
`timescale 1ns/1ps
module tcsc_coder #(
    parameter logic [95:0] TRELLIS_NEXT = tcsc_pkg::tcsc_trellis_default(),
    parameter logic [7:0] TRELLIS_Y0 = tcsc_pkg::Y0_DEFAULT,
    parameter logic [895:0] MAP_TABLE = tcsc_pkg::tcsc_map_default()
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic one_pair,
    input wire logic exchange_side_unit,
    input wire logic coded_mode,
    input wire logic tx_lock_req,
    input wire logic rx_lock_req,
    input wire logic tx_bit,
    input wire logic tx_bit_valid,
    output logic tx_bit_ready,
    output tcsc_pkg::tcsc_sym_t tx_sym,
    output logic tx_sym_valid,
    output logic tx_underrun,
    output logic tx_locked,
    input wire logic [6:0] rx_point,
    input wire logic rx_point_valid,
    output logic rx_bit,
    output logic rx_bit_valid,
    output logic rx_code_err,
    output logic rx_locked
);
    logic [31:0] nco;
    logic sym_tick;
    logic [22:0] tx_scr;
    logic [22:0] rx_scr;
    logic [5:0] tx_grp;
    logic [2:0] tx_cnt;
    logic [2:0] next_tx_cnt;
    logic [2:0] grp_len;
    logic [2:0] tstate;
    logic [2:0] rstate;
    logic [5:0] rx_grp;
    logic [2:0] rx_left;
    logic [6:0] rx_inv;
    logic tx_accept;
    logic tx_gen;
    logic tx_scr_bit;
    logic rx_gen;
    logic redundant_trellis_bit;
    logic info_bit_first;
    logic info_bit_second;
    logic [6:0] tx_z;
    tcsc_pkg::tcsc_scr_mode_t tx_mode;
    tcsc_pkg::tcsc_scr_mode_t rx_mode;

    // Symbol rate from a phase accumulator
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            nco <= tcsc_pkg::NCO_RST;
            sym_tick <= 1'b0;
        end else begin
            {sym_tick, nco} <= {1'b0, nco} + {1'b0, one_pair ? tcsc_pkg::NCO_INC_ONE_PAIR
                                                          : tcsc_pkg::NCO_INC_TWO_PAIR};
        end
    end

    // Bits per symbol times symbol rate gives the line bit rate
    assign grp_len = !coded_mode ? tcsc_pkg::GRP_UNCODED :
                     one_pair ? tcsc_pkg::GRP_ONE_PAIR : tcsc_pkg::GRP_TWO_PAIR;
    assign tx_accept = tx_bit_valid && tx_bit_ready;

    // Polynomial chosen by which end we are; the receive side takes the other one
    always_comb begin
        if (exchange_side_unit) begin
            tx_gen = tx_scr[tcsc_pkg::TAP_EXCHANGE - 1] ^ tx_scr[tcsc_pkg::SCR_LEN - 1];
            rx_gen = rx_scr[tcsc_pkg::TAP_CUSTOMER - 1] ^ rx_scr[tcsc_pkg::SCR_LEN - 1];
        end else begin
            tx_gen = tx_scr[tcsc_pkg::TAP_CUSTOMER - 1] ^ tx_scr[tcsc_pkg::SCR_LEN - 1];
            rx_gen = rx_scr[tcsc_pkg::TAP_EXCHANGE - 1] ^ rx_scr[tcsc_pkg::SCR_LEN - 1];
        end
    end

    assign tx_scr_bit = tx_bit ^ tx_gen;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_scr <= tcsc_pkg::SCR_RST;
        end else if (tx_accept) begin
            if (tx_mode == tcsc_pkg::TCSC_SELF_SYNC) begin
                tx_scr <= {tx_scr[21:0], tx_scr_bit};
            end else begin
                tx_scr <= {tx_scr[21:0], tx_gen};
            end
        end
    end

    // Dropping the lock request returns to start-up scrambling
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_mode <= tcsc_pkg::TCSC_SELF_SYNC;
        end else if (!tx_lock_req) begin
            tx_mode <= tcsc_pkg::TCSC_SELF_SYNC;
        end else if (tx_accept && tx_bit) begin
            tx_mode <= tcsc_pkg::TCSC_LOCKED;
        end
    end
    assign tx_locked = (tx_mode == tcsc_pkg::TCSC_LOCKED);

    // Group filling; ready is registered from the next count so it lands in the same cycle as the count
    always_comb begin
        next_tx_cnt = tx_cnt;
        if (sym_tick && tx_cnt >= grp_len) begin
            next_tx_cnt = 3'h0;
        end else if (tx_accept) begin
            next_tx_cnt = tx_cnt + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_cnt <= 3'h0;
            tx_grp <= 6'h0;
            tx_bit_ready <= 1'b0;
        end else begin
            tx_cnt <= next_tx_cnt;
            tx_bit_ready <= (next_tx_cnt < grp_len);
            if (sym_tick && tx_cnt >= grp_len) begin
                tx_grp <= 6'h0;
            end else if (tx_accept) begin
                tx_grp[tx_cnt] <= tx_scr_bit;
            end
        end
    end

    assign info_bit_first = tx_grp[0];
    assign info_bit_second = tx_grp[1];
    assign redundant_trellis_bit = TRELLIS_Y0[tstate];
    assign tx_z = {tx_grp, redundant_trellis_bit};

    // Encoder state moves only on coded symbols
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tstate <= tcsc_pkg::TRELLIS_RST;
        end else if (!coded_mode) begin
            tstate <= tcsc_pkg::TRELLIS_RST;
        end else if (sym_tick && tx_cnt >= grp_len) begin
            tstate <= TRELLIS_NEXT[{tstate, info_bit_second, info_bit_first} * 3 +: 3];
        end
    end

    // A tick without a full group loses that symbol slot and reports it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_sym <= '0;
            tx_sym_valid <= 1'b0;
            tx_underrun <= 1'b0;
        end else begin
            tx_sym_valid <= sym_tick && tx_cnt >= grp_len;
            tx_underrun <= sym_tick && tx_cnt < grp_len;
            if (sym_tick && tx_cnt >= grp_len) begin
                if (coded_mode) begin
                    tx_sym.mapped <= tx_z;
                    tx_sym.point <= MAP_TABLE[tx_z * 7 +: 7];
                end else begin
                    tx_sym.mapped <= {1'b0, tx_grp};
                    tx_sym.point <= {1'b0, tx_grp};
                end
            end
        end
    end

    // Receive: inverse map by search, then hard-decision trellis check
    always_comb begin
        rx_inv = 7'h0;
        for (int i = 0; i < tcsc_pkg::MAP_POINTS; i++) begin
            if (MAP_TABLE[i * 7 +: 7] == rx_point) begin
                rx_inv = 7'(i);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rstate <= tcsc_pkg::TRELLIS_RST;
            rx_code_err <= 1'b0;
        end else begin
            rx_code_err <= rx_point_valid && coded_mode && (rx_inv[0] != TRELLIS_Y0[rstate]);
            if (!coded_mode) begin
                rstate <= tcsc_pkg::TRELLIS_RST;
            end else if (rx_point_valid) begin
                rstate <= TRELLIS_NEXT[{rstate, rx_inv[2], rx_inv[1]} * 3 +: 3];
            end
        end
    end

    // Serialise lsb first; the symbol period far exceeds six cycles
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_grp <= 6'h0;
            rx_left <= 3'h0;
        end else if (rx_point_valid) begin
            rx_grp <= coded_mode ? rx_inv[6:1] : rx_point[5:0];
            rx_left <= grp_len;
        end else if (rx_left != 3'h0) begin
            rx_grp <= {1'b0, rx_grp[5:1]};
            rx_left <= rx_left - 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_scr <= tcsc_pkg::SCR_RST;
            rx_mode <= tcsc_pkg::TCSC_SELF_SYNC;
            rx_bit <= 1'b0;
            rx_bit_valid <= 1'b0;
        end else begin
            rx_bit_valid <= (rx_left != 3'h0) && !rx_point_valid;
            if (rx_left != 3'h0 && !rx_point_valid) begin
                rx_bit <= rx_grp[0] ^ rx_gen;
                if (rx_mode == tcsc_pkg::TCSC_SELF_SYNC) begin
                    rx_scr <= {rx_scr[21:0], rx_grp[0]};
                end else begin
                    rx_scr <= {rx_scr[21:0], rx_gen};
                end
                if (rx_lock_req && (rx_grp[0] ^ rx_gen)) begin
                    rx_mode <= tcsc_pkg::TCSC_LOCKED;
                end
            end
            if (!rx_lock_req) begin
                rx_mode <= tcsc_pkg::TCSC_SELF_SYNC;
            end
        end
    end
    assign rx_locked = (rx_mode == tcsc_pkg::TCSC_LOCKED);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Ready is registered from the next count, so it matches the count in every cycle except the first after reset
    ready_vs_count_a: assert property ($past(rst_b)
        |-> tx_bit_ready == (tx_cnt < grp_len))
        else $error("ready disagrees with group count");
    sym_on_tick_a: assert property (tx_sym_valid |-> $past(sym_tick))
        else $error("symbol issued off the rate tick");
    redundant_bit_a: assert property (sym_tick && tx_cnt >= grp_len && coded_mode
        |=> tx_sym.mapped[0] == $past(TRELLIS_Y0[tstate]))
        else $error("redundant bit not from encoder state");
    uncoded_range_a: assert property (sym_tick && tx_cnt >= grp_len && !coded_mode
        |=> !tx_sym.point[6])
        else $error("uncoded symbol outside 64 points");
    two_pair_width_a: assert property (sym_tick && tx_cnt >= grp_len && coded_mode && !one_pair
        |=> !tx_sym.mapped[6])
        else $error("two-pair symbol used bit six");
    lock_on_one_a: assert property ($rose(tx_locked) |-> $past(tx_accept && tx_bit))
        else $error("lock taken on a zero bit");
    self_sync_fb_a: assert property (tx_accept && !tx_locked
        |=> tx_scr[0] == $past(tx_scr_bit))
        else $error("scrambler output not fed back");
    rx_bit_count_a: assert property (rx_point_valid && one_pair && coded_mode
        |=> rx_left == 3'h6 ##1 rx_bit_valid [*6] ##1 !rx_bit_valid)
        else $error("receive group length wrong");
    locked_gen_a: assert property (tx_accept && tx_locked
        |=> tx_scr[0] == $past(tx_gen))
        else $error("locked scrambler not free-running");
    underrun_tick_a: assert property (tx_underrun
        |-> $past(sym_tick) && !tx_sym_valid)
        else $error("underrun reported off the rate tick");
    full_group_a: assert property (tx_sym_valid
        |-> $past(tx_cnt) == $past(grp_len))
        else $error("symbol built from a wrong bit count");
    rx_lock_one_a: assert property ($rose(rx_locked) |-> rx_bit_valid && rx_bit)
        else $error("receive lock taken on a zero bit");
    code_err_clear_a: assert property (rx_point_valid && coded_mode
        && rx_inv[0] == TRELLIS_Y0[rstate] |=> !rx_code_err)
        else $error("code error on a matching redundant bit");

    coded_sym_c: cover property (tx_sym_valid && coded_mode && one_pair);
    lock_c: cover property ($rose(tx_locked));
    rx_err_c: cover property (rx_code_err);
    uncoded_sym_c: cover property (tx_sym_valid && !coded_mode);
    rx_lock_c: cover property ($rose(rx_locked));
endmodule

// ==== tcsc_peer_model.sv ====
// Peer transceiver on the line side: descrambles our symbols and sends its own.
// Assumes the coder runs its default trellis tables and identity point table.
`timescale 1ns/1ps
module tcsc_peer_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic one_pair,
    input wire logic coded_mode,
    input wire logic exch,
    input wire tcsc_pkg::tcsc_sym_t tx_sym,
    input wire logic tx_sym_valid,
    output logic [6:0] rx_point,
    output logic rx_point_valid
);
    logic [22:0] rh, th;
    logic [2:0] rs, ts;
    logic [5:0] grp;
    bit q[$];
    int fmt_err, n_sym, gap, cnt, len, rtap, ttap;
    assign rtap = exch ? 18 : 5;
    assign ttap = exch ? 5 : 18;
    assign len = (one_pair || !coded_mode) ? 6 : 5;
    initial begin
        rx_point = 7'h00;
        rx_point_valid = 1'b0;
    end
    always @(posedge ref_clk) begin
        cnt++;
        if (!rst_b) begin
            rh = '0;
            th = '0;
            rs = '0;
            ts = '0;
            q.delete();
            fmt_err = 0;
            n_sym = 0;
        end else if (tx_sym_valid === 1'b1) begin
            gap = cnt;
            cnt = 0;
            n_sym++;
            grp = coded_mode ? tx_sym.mapped[6:1] : tx_sym.mapped[5:0];
            if (tx_sym.point !== tx_sym.mapped) fmt_err++;
            if ((len == 5 || !coded_mode) && tx_sym.mapped[6] !== 1'b0) fmt_err++;
            if (coded_mode && tx_sym.mapped[0] !== rs[0]) fmt_err++;
            if (coded_mode) rs = {rs[0], rs[2] ^ grp[1], rs[1] ^ grp[0]};
            for (int i = 0; i < len; i++) begin
                q.push_back(grp[i] ^ rh[rtap - 1] ^ rh[22]);
                rh = {rh[21:0], grp[i]};
            end
        end
    end
    // Strobes are spaced 13 cycles apart, well over the coder's minimum
    task automatic send_sym(input logic [5:0] data, input bit bad);
        logic [5:0] g;
        g = '0;
        for (int i = 0; i < len; i++) begin
            g[i] = data[i] ^ th[ttap - 1] ^ th[22];
            th = {th[21:0], g[i]};
        end
        @(negedge ref_clk);
        rx_point = coded_mode ? {g, ts[0] ^ bad} : {1'b0, g};
        if (coded_mode) ts = {ts[0], ts[2] ^ g[1], ts[1] ^ g[0]};
        rx_point_valid = 1'b1;
        @(negedge ref_clk);
        rx_point_valid = 1'b0;
        // Released point must not look like a held value
        rx_point = ~rx_point;
        repeat (11) @(negedge ref_clk);
    endtask
endmodule

// ==== tb_trellis_cap_scrambler_coder.sv ====
// Self-checking bench for the symbol coder with a peer model on the line side.
// Assumes default trellis and identity point tables in the coder.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
        n_mismatch++; \
    end \
end
module tb_trellis_cap_scrambler_coder;
    logic ref_clk, rst_b, one_pair, exchange_side_unit, coded_mode;
    logic tx_lock_req, rx_lock_req, tx_bit, tx_bit_valid, rx_point_valid;
    logic tx_bit_ready, tx_sym_valid, tx_underrun, tx_locked;
    logic rx_bit, rx_bit_valid, rx_code_err, rx_locked;
    logic [6:0] rx_point;
    tcsc_pkg::tcsc_sym_t tx_sym;
    bit rxq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int n_code_err, n_underrun, cycles;

    tcsc_coder dut (.ref_clk(ref_clk), .rst_b(rst_b), .one_pair(one_pair),
        .exchange_side_unit(exchange_side_unit), .coded_mode(coded_mode),
        .tx_lock_req(tx_lock_req), .rx_lock_req(rx_lock_req), .tx_bit(tx_bit),
        .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready), .tx_sym(tx_sym),
        .tx_sym_valid(tx_sym_valid), .tx_underrun(tx_underrun), .tx_locked(tx_locked),
        .rx_point(rx_point), .rx_point_valid(rx_point_valid), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .rx_code_err(rx_code_err), .rx_locked(rx_locked));
    tcsc_peer_model peer (.ref_clk(ref_clk), .rst_b(rst_b), .one_pair(one_pair),
        .coded_mode(coded_mode), .exch(!exchange_side_unit), .tx_sym(tx_sym),
        .tx_sym_valid(tx_sym_valid), .rx_point(rx_point), .rx_point_valid(rx_point_valid));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (rx_bit_valid === 1'b1) rxq.push_back(rx_bit);
        if (rx_code_err === 1'b1) n_code_err++;
        if (tx_underrun === 1'b1) n_underrun++;
        if (cycles == 30000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic start(input logic op, input logic ex, input logic cm);
        @(negedge ref_clk);
        rst_b = 1'b0;
        one_pair = op;
        exchange_side_unit = ex;
        coded_mode = cm;
        tx_lock_req = 1'b0;
        rx_lock_req = 1'b0;
        tx_bit_valid = 1'b0;
        repeat (20) @(negedge ref_clk);
        // Outputs stay quiet while reset is held
        `CHK({tx_bit_ready, tx_sym_valid, tx_locked, rx_bit_valid, rx_locked}, 5'h00)
        rst_b = 1'b1;
        rxq.delete();
        n_code_err = 0;
        n_underrun = 0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic feed(input logic [63:0] data, input int n);
        int i;
        int guard;
        i = 0;
        guard = 0;
        while (i < n && guard < 5000) begin
            @(negedge ref_clk);
            guard++;
            tx_bit_valid = tx_bit_ready;
            tx_bit = data[i];
            if (tx_bit_ready === 1'b1) i++;
        end
        @(negedge ref_clk);
        tx_bit_valid = 1'b0;
        tx_bit = ~tx_bit;
        guard = 0;
        while (peer.q.size() < n && guard < 5000) begin
            @(negedge ref_clk);
            guard++;
        end
    endtask
    task automatic tx_check(input logic [63:0] data, input int n, input int gmin, input int gmax);
        feed(data, n);
        `CHK(peer.q.size(), n)
        for (int i = 0; i < n; i++) `CHK(peer.q[i], data[i])
        `CHK(peer.fmt_err, 0)
        `CHK(peer.gap >= gmin && peer.gap <= gmax, 1'b1)
        repeat (300) @(negedge ref_clk);
        // Feeding stopped, so symbol slots must now be reported lost
        `CHK(n_underrun > 0, 1'b1)
    endtask
    task automatic tx_two_pair_customer();
        start(1'b0, 1'b0, 1'b1);
        tx_check(64'h0003_a5c3_96f0_7e1d, 50, 171, 172);
        `CHK(peer.n_sym, 10)
    endtask
    task automatic tx_one_pair_exchange();
        start(1'b1, 1'b1, 1'b1);
        tx_check(64'h0000_5b3e_c817_64d9, 48, 103, 104);
        `CHK(peer.n_sym, 8)
    endtask
    task automatic tx_uncoded();
        start(1'b0, 1'b0, 1'b0);
        tx_check(64'h0000_e4c1_77a2_905b, 48, 171, 172);
        `CHK(peer.n_sym, 8)
    endtask
    task automatic rx_coded(input logic op, input logic ex, input logic [63:0] data);
        int len;
        len = op ? 6 : 5;
        start(op, ex, 1'b1);
        for (int k = 0; k < 8; k++) peer.send_sym(data[k * len +: 6], k == 3);
        `CHK(rxq.size(), 8 * len)
        for (int i = 0; i < 8 * len; i++) `CHK(rxq[i], data[i])
        `CHK(n_code_err, 1)
    endtask
    task automatic lock_switch();
        start(1'b0, 1'b0, 1'b1);
        tx_lock_req = 1'b1;
        rx_lock_req = 1'b1;
        feed(64'h0, 5);
        `CHK(tx_locked, 1'b0)
        feed(64'h1f, 5);
        `CHK(tx_locked, 1'b1)
        `CHK(rx_locked, 1'b0)
        peer.send_sym(6'h3f, 1'b0);
        `CHK(rx_locked, 1'b1)
    endtask

    initial begin
        rst_b = 1'b0;
        one_pair = 1'b0;
        exchange_side_unit = 1'b0;
        coded_mode = 1'b0;
        tx_lock_req = 1'b0;
        rx_lock_req = 1'b0;
        tx_bit = 1'b0;
        tx_bit_valid = 1'b0;
        tx_two_pair_customer();
        tx_one_pair_exchange();
        tx_uncoded();
        rx_coded(1'b0, 1'b0, 64'h0000_3c96_e1a7_5d28);
        rx_coded(1'b1, 1'b1, 64'h0000_b74e_0f93_c65a);
        lock_switch();
        test_done();
    end
endmodule
